//--- include/fcl_pkg.sv
package fcl_pkg;

  // timing
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned STARTUP_UNIT_MS   = 1;
  localparam int unsigned STARTUP_UNIT_CYC  = CLK_HZ / 1000 * STARTUP_UNIT_MS;
  localparam logic [9:0]  PIN_HOLD_SLOW_CYC = 10'h300;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_OSC    = 6'h02;
  localparam logic [5:0] IDX_TCD    = 6'h04;
  localparam logic [5:0] IDX_SYS0   = 6'h05;
  localparam logic [5:0] IDX_SYS1   = 6'h06;
  localparam logic [5:0] IDX_APP    = 6'h07;
  localparam logic [5:0] IDX_BOOT   = 6'h08;
  localparam logic [5:0] IDX_LOCK   = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;

  // field positions and implemented-bit masks
  localparam int unsigned OSC_LOCK_BIT = 7;
  localparam int unsigned FREQ_LSB     = 0;
  localparam int unsigned CRC_LSB      = 6;
  localparam int unsigned PIN_LSB      = 2;
  localparam int unsigned EEPROM_KEEP_ON_ERASE_BIT   = 0;
  localparam int unsigned SUT_LSB      = 0;
  localparam logic [7:0]  OSC_MASK     = 8'h83;
  localparam logic [7:0]  SYS0_MASK    = 8'hcd;
  localparam logic [7:0]  SYS1_MASK    = 8'h07;

  // shadow values before the fuses are sampled
  localparam logic [7:0] OSC_RST  = 8'h02;
  localparam logic [7:0] SYS0_RST = 8'hc4;
  localparam logic [7:0] SYS1_RST = 8'h07;
  localparam logic [7:0] APP_RST  = 8'h00;
  localparam logic [7:0] BOOT_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h00;

  // field codes
  localparam logic [1:0] FREQ_16M      = 2'h1;
  localparam logic [1:0] FREQ_20M      = 2'h2;
  localparam logic [1:0] CRC_FLASH     = 2'h0;
  localparam logic [1:0] CRC_BOOT      = 2'h1;
  localparam logic [1:0] CRC_BOOT_APP  = 2'h2;
  localparam logic [1:0] CRC_DISABLED  = 2'h3;
  localparam logic [1:0] PIN_GPIO      = 2'h0;
  localparam logic [1:0] PIN_DEBUG     = 2'h1;
  localparam logic [1:0] PIN_RESET     = 2'h2;
  localparam logic [7:0] OPEN_CODE     = 8'hc5;
  localparam logic [7:0] SECTION_ZERO  = 8'h00;
  localparam logic [16:0] FLASH_BYTES_DEFAULT = 17'h10000;

  // status register bits
  localparam int unsigned STS_LOADED   = 0;
  localparam int unsigned STS_LOCKED   = 1;
  localparam int unsigned STS_PIN_HOLD = 2;
  localparam int unsigned STS_STARTUP  = 3;
  localparam int unsigned STS_FREQ_RSV = 4;
  localparam int unsigned STS_POR      = 5;

  typedef enum logic [1:0] {
    FCL_ST_LOAD = 2'b01,
    FCL_ST_RUN  = 2'b10
  } fcl_state_t;

  typedef struct packed {
    logic [7:0] osc;
    logic [7:0] control_timer;
    logic [7:0] sys0;
    logic [7:0] sys1;
    logic [7:0] app;
    logic [7:0] boot;
    logic [7:0] lock;
  } fcl_fuse_t;

  typedef struct packed {
    logic [7:0] freq_trim;
    logic [7:0] temp_trim;
  } fcl_trim_t;

  typedef struct packed {
    logic        osc_cal_lock_fuse;
    logic [1:0]  osc_frequency_select;
    logic        run_20m;
    logic        freq_reserved;
    logic [7:0]  osc_frequency_trim;
    logic [7:0]  osc_temperature_trim;
    logic [7:0]  timer_fault_control;
    logic [3:0]  compare_out_enable;
    logic [3:0]  compare_default_level;
    logic        compare_force_default;
    logic [1:0]  crc_scan_source;
    logic        crc_scan_enable;
    logic [16:0] crc_scan_end;
    logic        pin_gpio;
    logic        pin_debug_port;
    logic        pin_reset_input;
    logic        pin_out_hold;
    logic        eeprom_erase_on_chip_erase;
    logic        device_locked;
    logic        debug_bus_deny;
    logic [16:0] boot_section_end;
    logic [16:0] app_section_end;
    logic        code_run;
  } fcl_cfg_t;

endpackage

//--- src/fcl_fuse_loader.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Contract
// - oscillator lock fuse drives calibration lock
// - frequency code 1 is 16MHz, 2 is 20MHz
// - selected frequency picks factory trim values
// - timer fuse bits copied to fault control
// - timer settings reload only on power-on reset
// - bits 4-7 enable compare outputs
// - bits 0-3 give compare default levels
// - crc source selects scanned flash region
// - pin field selects gpio, debug, reset
// - gpio driver held off 768 slow cycles
// - retention bit keeps eeprom on chip erase
// - locked device always erases eeprom
// - power-on start-up delay 0ms, then doubling 1-64ms
// - app end in 256-byte units
// - app end zero means flash end
// - boot end 256-byte units, zero whole flash
// - lock code 0xc5 open, else locked
// - locked debug port denied system bus
module fcl_fuse_loader #(
  parameter int unsigned       STARTUP_UNIT_CYCLES = fcl_pkg::STARTUP_UNIT_CYC,
  parameter logic [16:0]       FLASH_BYTES         = fcl_pkg::FLASH_BYTES_DEFAULT
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // reset cause and fuse array
  input  wire logic             por_i,
  input  wire fcl_pkg::fcl_fuse_t fuse_i,
  input  wire fcl_pkg::fcl_trim_t cal_16m_i,
  input  wire fcl_pkg::fcl_trim_t cal_20m_i,
  // slow clock tick and debug entry
  input  wire logic             slow_tick_i,
  input  wire logic             debug_entry_i,
  input  wire logic             fault_on_debug_i,
  // avalon-mm slave
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic [31:0]           avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // distributed configuration
  output fcl_pkg::fcl_cfg_t     cfg_o
);
  import fcl_pkg::*;

  typedef struct packed {
    fcl_state_t  state;
    fcl_fuse_t   sh;
    logic        por;
    logic        ack;
    logic        wait_n;
    logic [31:0] rdata;
    logic [9:0]  hold_cnt;
    logic        hold;
    logic [16:0] ms_div;
    logic [6:0]  ms_cnt;
    logic [6:0]  ms_target;
    logic        busy;
    fcl_cfg_t    cfg;
  } fcl_reg_t;

  fcl_reg_t st;
  fcl_reg_t next_st;
  fcl_reg_t rst_st;

  // word index of an aligned byte address, or all ones
  function automatic logic [5:0] fcl_index(input logic [7:0] addr);
    if (addr[1:0] == 2'h0) begin
      fcl_index = addr[7:2];
    end else begin
      fcl_index = 6'h3f;
    end
  endfunction

  function automatic logic [7:0] fcl_read(input fcl_reg_t s, input logic [5:0] idx);
    logic [7:0] sts;
    sts = 8'h00;
    sts[STS_LOADED]   = (s.state == FCL_ST_RUN);
    sts[STS_LOCKED]   = s.cfg.device_locked;
    sts[STS_PIN_HOLD] = s.hold;
    sts[STS_STARTUP]  = s.busy;
    sts[STS_FREQ_RSV] = s.cfg.freq_reserved;
    sts[STS_POR]      = s.por;
    case (idx)
      IDX_OSC:    fcl_read = s.sh.osc & OSC_MASK;
      IDX_TCD:    fcl_read = s.sh.control_timer;
      IDX_SYS0:   fcl_read = s.sh.sys0 & SYS0_MASK;
      IDX_SYS1:   fcl_read = s.sh.sys1 & SYS1_MASK;
      IDX_APP:    fcl_read = s.sh.app;
      IDX_BOOT:   fcl_read = s.sh.boot;
      IDX_LOCK:   fcl_read = s.sh.lock;
      IDX_STATUS: fcl_read = sts;
      default:    fcl_read = 8'h00;
    endcase
  endfunction

  // section boundary in bytes; zero means end of flash
  function automatic logic [16:0] fcl_bound(input logic [7:0] units);
    if (units == SECTION_ZERO) begin
      fcl_bound = FLASH_BYTES;
    end else begin
      fcl_bound = {1'b0, units, 8'h00};
    end
  endfunction

  always_comb begin
    logic [1:0] freq;
    logic [1:0] crc;
    logic [1:0] pin;
    logic [2:0] startup_delay_select;
    freq = 2'h0;
    crc = 2'h0;
    pin = 2'h0;
    startup_delay_select = 3'h0;

    // values taken under reset; timer settings survive non-power-on resets
    rst_st = '0;
    rst_st.state = FCL_ST_LOAD;
    rst_st.sh.osc = OSC_RST;
    rst_st.sh.sys0 = SYS0_RST;
    rst_st.sh.sys1 = SYS1_RST;
    rst_st.sh.app = APP_RST;
    rst_st.sh.boot = BOOT_RST;
    rst_st.sh.lock = LOCK_RST;
    rst_st.sh.control_timer = st.sh.control_timer;
    rst_st.cfg.timer_fault_control = st.cfg.timer_fault_control;
    rst_st.cfg.compare_out_enable = st.cfg.compare_out_enable;
    rst_st.cfg.compare_default_level = st.cfg.compare_default_level;
    rst_st.cfg.device_locked = 1'b1;
    rst_st.cfg.debug_bus_deny = 1'b1;
    rst_st.cfg.eeprom_erase_on_chip_erase = 1'b1;
    rst_st.wait_n = 1'b1;

    next_st = st;
    next_st.cfg.compare_force_default = 1'b0;

    case (st.state)
      FCL_ST_LOAD: begin
        // single sample of the fuse array after reset release
        next_st.sh.osc  = fuse_i.osc & OSC_MASK;
        next_st.sh.sys0 = fuse_i.sys0 & SYS0_MASK;
        next_st.sh.sys1 = fuse_i.sys1 & SYS1_MASK;
        next_st.sh.app  = fuse_i.app;
        next_st.sh.boot = fuse_i.boot;
        next_st.sh.lock = fuse_i.lock;
        next_st.por = por_i;
        if (por_i) begin
          next_st.sh.control_timer = fuse_i.control_timer;
          next_st.cfg.compare_force_default = 1'b1;
        end
        pin = fuse_i.sys0[PIN_LSB +: 2];
        next_st.hold = (pin == PIN_GPIO);
        next_st.hold_cnt = 10'h000;
        startup_delay_select = fuse_i.sys1[SUT_LSB +: 3];
        next_st.busy = por_i && (startup_delay_select != 3'h0);
        next_st.ms_target = (startup_delay_select == 3'h0) ? 7'h00 : 7'(7'h01 << (startup_delay_select - 3'h1));
        next_st.ms_cnt = 7'h00;
        next_st.ms_div = 17'h00000;
        next_st.state = FCL_ST_RUN;
      end
      FCL_ST_RUN: begin
        if (st.hold && slow_tick_i) begin
          if (st.hold_cnt == PIN_HOLD_SLOW_CYC - 10'h001) begin
            next_st.hold = 1'b0;
          end else begin
            next_st.hold_cnt = st.hold_cnt + 10'h001;
          end
        end
        if (st.busy) begin
          if (st.ms_div == 17'(STARTUP_UNIT_CYCLES - 1)) begin
            next_st.ms_div = 17'h00000;
            next_st.ms_cnt = st.ms_cnt + 7'h01;
            if (st.ms_cnt + 7'h01 == st.ms_target) begin
              next_st.busy = 1'b0;
            end
          end else begin
            next_st.ms_div = st.ms_div + 17'h00001;
          end
        end
        if (debug_entry_i && fault_on_debug_i) begin
          next_st.cfg.compare_force_default = 1'b1;
        end
      end
      default: begin
        next_st.state = FCL_ST_LOAD;
      end
    endcase

    // bus slave: request seen, answer one cycle later
    next_st.ack = 1'b0;
    if ((avs_read_i || avs_write_i) && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = {24'h000000, fcl_read(st, fcl_index(avs_address_i))};
    end
    if (st.ack && avs_write_i && avs_byteenable_i[0] && fcl_index(avs_address_i) == IDX_LOCK) begin
      next_st.sh.lock = avs_writedata_i[7:0];
    end
    next_st.wait_n = !next_st.ack;

    // configuration handed to consumers
    freq = next_st.sh.osc[FREQ_LSB +: 2];
    next_st.cfg.osc_cal_lock_fuse = next_st.sh.osc[OSC_LOCK_BIT];
    next_st.cfg.osc_frequency_select = freq;
    next_st.cfg.run_20m = (freq != FREQ_16M);
    next_st.cfg.freq_reserved = (freq != FREQ_16M) && (freq != FREQ_20M);
    if (freq == FREQ_16M) begin
      next_st.cfg.osc_frequency_trim = cal_16m_i.freq_trim;
      next_st.cfg.osc_temperature_trim = cal_16m_i.temp_trim;
    end else begin
      next_st.cfg.osc_frequency_trim = cal_20m_i.freq_trim;
      next_st.cfg.osc_temperature_trim = cal_20m_i.temp_trim;
    end

    next_st.cfg.timer_fault_control = next_st.sh.control_timer;
    next_st.cfg.compare_out_enable = next_st.sh.control_timer[7:4];
    next_st.cfg.compare_default_level = next_st.sh.control_timer[3:0];

    crc = next_st.sh.sys0[CRC_LSB +: 2];
    next_st.cfg.crc_scan_source = crc;
    next_st.cfg.crc_scan_enable = (crc != CRC_DISABLED);
    next_st.cfg.boot_section_end = fcl_bound(next_st.sh.boot);
    next_st.cfg.app_section_end = fcl_bound(next_st.sh.app);
    case (crc)
      CRC_BOOT:     next_st.cfg.crc_scan_end = next_st.cfg.boot_section_end;
      CRC_BOOT_APP: next_st.cfg.crc_scan_end = next_st.cfg.app_section_end;
      default:      next_st.cfg.crc_scan_end = FLASH_BYTES;
    endcase

    pin = next_st.sh.sys0[PIN_LSB +: 2];
    next_st.cfg.pin_gpio = (pin == PIN_GPIO);
    next_st.cfg.pin_debug_port = (pin == PIN_DEBUG);
    next_st.cfg.pin_reset_input = (pin == PIN_RESET);
    next_st.cfg.pin_out_hold = next_st.hold;

    next_st.cfg.device_locked = (next_st.sh.lock != OPEN_CODE);
    next_st.cfg.debug_bus_deny = next_st.cfg.device_locked;
    next_st.cfg.eeprom_erase_on_chip_erase =
      !next_st.sh.sys0[EEPROM_KEEP_ON_ERASE_BIT] || next_st.cfg.device_locked;

    next_st.cfg.code_run = (next_st.state == FCL_ST_RUN) && !next_st.busy;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st <= rst_st;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.wait_n;
  assign cfg_o = st.cfg;

endmodule

//--- tb/fcl_fuse_loader_monitor.sv
`timescale 1ns/1ps
module fcl_fuse_loader_monitor
  import fcl_pkg::*;
(
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  // watched ports
  input wire logic               slow_tick_i,
  input wire logic               debug_entry_i,
  input wire logic               fault_on_debug_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic               avs_waitrequest_o,
  input wire fcl_pkg::fcl_trim_t cal_16m_i,
  input wire fcl_pkg::fcl_trim_t cal_20m_i,
  input wire fcl_pkg::fcl_cfg_t  cfg_o
);
  logic        up;
  logic [10:0] hcnt;
  // up is low in the load cycle
  always_ff @(posedge clk_i) begin
    up <= rst_b_i;
    hcnt <= cfg_o.pin_out_hold ? hcnt + 11'(slow_tick_i) : 11'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_req_answer: assert property (up && (avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
    else $error("request not answered");
  a_deny_locked: assert property (up |-> cfg_o.debug_bus_deny == cfg_o.device_locked)
    else $error("debug deny differs from lock");
  a_erase_locked: assert property (cfg_o.device_locked |-> cfg_o.eeprom_erase_on_chip_erase)
    else $error("locked part keeps eeprom");
  a_freq_run: assert property (up |-> cfg_o.run_20m == (cfg_o.osc_frequency_select != FREQ_16M))
    else $error("wrong oscillator rate");
  a_trim_pick: assert property (up && $stable(cal_16m_i) && $stable(cal_20m_i) |->
    {cfg_o.osc_frequency_trim, cfg_o.osc_temperature_trim} ==
    (cfg_o.osc_frequency_select == FREQ_16M ? cal_16m_i : cal_20m_i))
    else $error("wrong trim set");
  a_crc_off: assert property (up |-> cfg_o.crc_scan_enable == (cfg_o.crc_scan_source != CRC_DISABLED))
    else $error("crc enable wrong");
  a_hold_len: assert property (up && $fell(cfg_o.pin_out_hold) |-> hcnt == {1'b0, PIN_HOLD_SLOW_CYC})
    else $error("pin hold length wrong");
  a_debug_force: assert property (up && debug_entry_i && fault_on_debug_i |=> cfg_o.compare_force_default)
    else $error("no default force on debug");
  c_force: cover property (cfg_o.compare_force_default);
  c_hold: cover property ($fell(cfg_o.pin_out_hold));
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

bind fcl_fuse_loader fcl_fuse_loader_monitor mon (.clk_i, .rst_b_i, .slow_tick_i, .debug_entry_i,
  .fault_on_debug_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .cal_16m_i, .cal_20m_i, .cfg_o);

//--- tb/fcl_consumer_model.sv
`timescale 1ns/1ps
module fcl_consumer_model
  import fcl_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // configuration in
  input  wire fcl_pkg::fcl_cfg_t cfg_i,
  // slow tick and pin interrupt enable
  output logic                   slow_tick_o,
  output logic                   pin_irq_en_o
);
  // slow clock stand-in, one tick every second cycle
  always_ff @(posedge clk_i) begin
    slow_tick_o <= !slow_tick_o && rst_b_i;
    pin_irq_en_o <= cfg_i.pin_gpio && !cfg_i.pin_out_hold;
  end
endmodule

//--- tb/fcl_fuse_loader_bench.sv
`timescale 1ns/1ps
module fcl_fuse_loader_bench;
  import fcl_pkg::*;
  typedef struct packed {
    fcl_fuse_t   f;
    logic [7:0]  b;
    logic [16:0] be;
    logic [16:0] ae;
  } fcl_row_t;
  localparam logic [15:0] C16 = 16'h1a2b;
  localparam logic [15:0] C20 = 16'h3c4d;
  logic        clk_i = 0;
  logic        rst_b_i = 0;
  logic        por_i = 1;
  fcl_fuse_t   fuse_i = '0;
  logic        slow_tick_i;
  logic        debug_entry_i = 0;
  logic        fault_on_debug_i = 0;
  logic [7:0]  avs_address_i = '0;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0]  avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  fcl_cfg_t    cfg_o;
  logic        irq_en;
  logic [7:0]  q;
  logic [7:0]  got;
  fcl_fuse_t   f;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  // fuses, {lock fuse, 20m, crc on, locked, erase, gpio, debug, reset}, boot end, app end
  fcl_row_t rows [4] = '{
    '{'{8'h81, 8'h5a, 8'h01, 8'h00, 8'h10, 8'h04, 8'hc5}, 8'ha4, 17'h00400, 17'h01000},
    '{'{8'h02, 8'h00, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h7a, 17'h10000, 17'h10000},
    '{'{8'h03, 8'h00, 8'h88, 8'h00, 8'hff, 8'h01, 8'hc4}, 8'h79, 17'h00100, 17'h0ff00},
    '{'{8'h00, 8'h00, 8'hc9, 8'h00, 8'h20, 8'h08, 8'hc5}, 8'h41, 17'h00800, 17'h02000}};
  fcl_fuse_loader #(.STARTUP_UNIT_CYCLES(10)) uut (.clk_i, .rst_b_i, .por_i, .fuse_i, .cal_16m_i(C16),
    .cal_20m_i(C20), .slow_tick_i, .debug_entry_i, .fault_on_debug_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .cfg_o);
  fcl_consumer_model far (.clk_i, .rst_b_i, .cfg_i(cfg_o), .slow_tick_o(slow_tick_i), .pin_irq_en_o(irq_en));
  always #5 clk_i = ~clk_i;
  task final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task chk(input string s, input logic [16:0] e, input logic [16:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task rst(input logic p, input fcl_fuse_t x);
    rst_b_i <= 0;
    por_i <= p;
    fuse_i <= x;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    // waits until waitrequest drops; the cycle timeout ends a hung wait
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_readdata_o[7:0];
    avs_read_i <= 0;
    avs_write_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst(1'b1, rows[i].f);
      got = {cfg_o.osc_cal_lock_fuse, cfg_o.run_20m, cfg_o.crc_scan_enable, cfg_o.device_locked,
        cfg_o.eeprom_erase_on_chip_erase, cfg_o.pin_gpio, cfg_o.pin_debug_port, cfg_o.pin_reset_input};
      chk("bits", {9'h0, rows[i].b}, {9'h0, got});
      chk("boot", rows[i].be, cfg_o.boot_section_end);
      chk("app", rows[i].ae, cfg_o.app_section_end);
      chk("crc", rows[i].f.sys0[7:6] == CRC_BOOT ? rows[i].be : rows[i].f.sys0[7:6] == CRC_BOOT_APP ? rows[i].ae
        : FLASH_BYTES_DEFAULT, cfg_o.crc_scan_end);
      chk("trim", {1'b0, rows[i].f.osc[1:0] == FREQ_16M ? C16 : C20},
        {1'b0, cfg_o.osc_frequency_trim, cfg_o.osc_temperature_trim});
      chk("hold", {16'h0, rows[i].b[2]}, {16'h0, cfg_o.pin_out_hold});
      bus(1'b0, 8'h28, 8'h00);
      chk("lock", {9'h0, rows[i].f.lock}, {9'h0, q});
      $display("row %0d done", i);
    end
    f = rows[0].f;
    f.control_timer = 8'hc3;
    rst(1'b1, f);
    chk("tmr", 17'hc3, {9'h0, cfg_o.timer_fault_control});
    chk("en", 17'hc, {13'h0, cfg_o.compare_out_enable});
    chk("lvl", 17'h3, {13'h0, cfg_o.compare_default_level});
    chk("frc", 17'h1, {16'h0, cfg_o.compare_force_default});
    f.control_timer = 8'h5a;
    rst(1'b0, f);
    chk("tmr", 17'hc3, {9'h0, cfg_o.timer_fault_control});
    chk("frc", 17'h0, {16'h0, cfg_o.compare_force_default});
    chk("hold", 17'h1, {16'h0, cfg_o.pin_out_hold});
    repeat (1520) @(posedge clk_i);
    chk("hold", 17'h1, {16'h0, cfg_o.pin_out_hold});
    chk("irq", 17'h0, {16'h0, irq_en});
    repeat (30) @(posedge clk_i);
    chk("hold", 17'h0, {16'h0, cfg_o.pin_out_hold});
    chk("irq", 17'h1, {16'h0, irq_en});
    rst(1'b1, f);
    chk("tmr", 17'h5a, {9'h0, cfg_o.timer_fault_control});
    $display("timer and pin done");
    for (int k = 0; k < 2; k++) begin
      fault_on_debug_i <= k[0];
      debug_entry_i <= 1;
      @(posedge clk_i);
      debug_entry_i <= 0;
      #1;
      chk("dbg", {16'h0, k[0]}, {16'h0, cfg_o.compare_force_default});
      @(posedge clk_i);
    end
    bus(1'b1, 8'h28, 8'h00);
    chk("lck", 17'h1, {16'h0, cfg_o.device_locked});
    bus(1'b1, 8'h28, OPEN_CODE);
    chk("lck", 17'h0, {16'h0, cfg_o.device_locked});
    avs_byteenable_i <= 4'h0;
    bus(1'b1, 8'h28, 8'h00);
    chk("be", 17'h0, {16'h0, cfg_o.device_locked});
    avs_byteenable_i <= 4'h1;
    bus(1'b1, 8'h1c, 8'hff);
    bus(1'b0, 8'h1c, 8'h00);
    chk("ro", {9'h0, f.app}, {9'h0, q});
    bus(1'b0, 8'h30, 8'h00);
    chk("map", 17'h0, {9'h0, q});
    // loaded, pin hold and power-on seen, device open
    bus(1'b0, 8'h2c, 8'h00);
    chk("sts", 17'h25, {9'h0, q});
    $display("bus done");
    f.sys1 = 8'h03;
    rst(1'b1, f);
    chk("sut0", 17'h0, {16'h0, cfg_o.code_run});
    n = 0;
    while (cfg_o.code_run !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("sut", 17'h28, 17'(n));
    rst(1'b0, f);
    chk("sut1", 17'h1, {16'h0, cfg_o.code_run});
    $display("startup done");
    final_report();
  end
endmodule
